// ---- rtl/rss_pkg.sv ----
package rss_pkg;

	// ---------------------------------------------------------------
	// Timing
	// ---------------------------------------------------------------
	localparam int RSS_PUDT_MS = 72;
	// Internal RC oscillator rate in Hz
	localparam int RSS_RC_HZ = 32000;
	localparam int RSS_PUDT_TICKS = RSS_PUDT_MS * RSS_RC_HZ / 1000;
	localparam int RSS_OSC_STARTUP_CYCLES = 1024;

	// ---------------------------------------------------------------
	// Oscillator mode encoding
	// ---------------------------------------------------------------
	localparam logic [2:0] RSS_OSC_XTAL_LOW = 3'h0;
	localparam logic [2:0] RSS_OSC_XTAL_MID = 3'h1;
	localparam logic [2:0] RSS_OSC_XTAL_HIGH = 3'h2;

	// ---------------------------------------------------------------
	// Register reset values
	// ---------------------------------------------------------------
	localparam logic [7:0] RSS_PC_LOW_RST = 8'h00;
	localparam logic [7:0] RSS_STATUS_POR = 8'h18;
	localparam logic [7:0] RSS_STATUS_WARM_HI = 8'h00;
	localparam logic [7:0] RSS_OPTION_RST = 8'hFF;
	localparam logic [5:0] RSS_DIR_RST = 6'h3F;
	localparam logic [7:0] RSS_INT_CTL_RST = 8'h00;
	localparam logic [6:0] RSS_TIMER1_CTL_POR = 7'h00;

	// Status field positions
	localparam int RSS_STATUS_TO_BIT = 4;
	localparam int RSS_STATUS_PD_BIT = 3;

	typedef enum logic [1:0] {
		RSS_HOLD,
		RSS_PUDT,
		RSS_OSC_WAIT,
		RSS_RUN
	} rss_state_t;

endpackage

// ---- rtl/rss_sync.sv ----
`timescale 1ns/10ps
`default_nettype none
module rss_sync
	import rss_pkg::*;
(
	input wire logic i_mclk, // System clock
	input wire logic i_rst_b, // Async reset
	input wire logic i_async, // Pin level
	output logic o_sync // Synchronised level
);

	typedef struct packed {
		logic s1;
		logic s2;
	} rss_sync_st_t;

	rss_sync_st_t st;
	rss_sync_st_t next_st;

	always_comb begin
		next_st = st;
		next_st.s1 = i_async;
		next_st.s2 = st.s1;
	end

	always_ff @(posedge i_mclk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign o_sync = st.s2;

endmodule // rss_sync
`default_nettype wire

// ---- rtl/rss_seq.sv ----
// Behaviour
// - Hold reset while supply below operating level
// - Undervoltage detector holds reset until threshold
// - Falling supply alone causes no power-on reset
// - Fixed 72 ms delay after power-on/undervoltage
// - Delay timed by internal RC oscillator
// - Hold reset while delay timer runs
// - Disable cfg one disables delay timer
// - Count 1024 external oscillator cycles after delay
// - Start-up count only in crystal modes
// - Start-up count only on power-on or wake
// - Power-on loads documented register values
// - Warm resets load partial values, keep timer one
`timescale 1ns/10ps
`default_nettype none
module rss_seq
	import rss_pkg::*;
(
	input wire logic i_mclk, // System clock
	input wire logic i_rst_b, // Async reset, active low
	input wire logic i_supply_ok, // Power-on detector: supply adequate
	input wire logic i_uv_en, // Undervoltage detector enabled
	input wire logic i_uv_ok, // Supply above undervoltage threshold
	input wire logic i_power_up_delay_disable_cfg, // 1 disables delay
	input wire logic i_rc_osc, // Internal RC oscillator
	input wire logic i_external_osc_input, // External oscillator input
	input wire logic [2:0] i_osc_mode, // Oscillator mode
	input wire logic i_master_clear_pin_b, // Master clear, active low
	input wire logic i_watchdog_reset_source, // Watchdog reset pulse
	input wire logic i_sleep_wake, // Wake-up from sleep pulse
	input wire logic [6:0] i_timer_one_control_reg, // Current timer-one ctl
	input wire logic i_status_lo_keep, // Held status bit 0 source
	output logic o_chip_rst_b, // Internal reset, active low
	output logic o_load_por, // Pulse: power-on values loaded
	output logic o_load_warm, // Pulse: warm values loaded
	output logic [7:0] o_program_counter_low, // Reset value
	output logic [7:0] o_status, // Reset value
	output logic [7:0] o_option, // Reset value
	output logic [5:0] o_pin_direction_reg, // Reset value
	output logic [7:0] o_interrupt_control_reg, // Reset value
	output logic [6:0] o_timer_one_control_reg // Reset value
);

	// ---------------------------------------------------------------
	// Input synchronisers
	// ---------------------------------------------------------------
	logic supply_ok_s;
	logic uv_ok_s;
	logic rc_s;
	logic ext_s;
	logic clear_b_s;

	rss_sync u_sync_sup (.i_mclk(i_mclk), .i_rst_b(i_rst_b),
		.i_async(i_supply_ok), .o_sync(supply_ok_s));
	rss_sync u_sync_uv (.i_mclk(i_mclk), .i_rst_b(i_rst_b),
		.i_async(i_uv_ok), .o_sync(uv_ok_s));
	rss_sync u_sync_rc (.i_mclk(i_mclk), .i_rst_b(i_rst_b),
		.i_async(i_rc_osc), .o_sync(rc_s));
	rss_sync u_sync_ext (.i_mclk(i_mclk), .i_rst_b(i_rst_b),
		.i_async(i_external_osc_input), .o_sync(ext_s));
	rss_sync u_sync_clear (.i_mclk(i_mclk), .i_rst_b(i_rst_b),
		.i_async(i_master_clear_pin_b), .o_sync(clear_b_s));

	// ---------------------------------------------------------------
	// State
	// ---------------------------------------------------------------
	typedef struct packed {
		rss_state_t state;
		logic powered;
		logic uv_low;
		logic cold;
		logic rc_d;
		logic ext_d;
		logic [11:0] pudt_cnt;
		logic [10:0] osc_cnt;
		logic rst_b;
		logic load_por;
		logic load_warm;
		logic [7:0] pc_low;
		logic [7:0] status;
		logic [7:0] option;
		logic [5:0] dir;
		logic [7:0] int_ctl;
		logic [6:0] timer1_ctl;
	} rss_st_t;

	rss_st_t st;
	rss_st_t next_st;

	logic crystal;
	logic rc_rise;
	logic ext_rise;
	logic supply_hold;
	logic warm_evt;

	always_comb begin
		crystal = (i_osc_mode == RSS_OSC_XTAL_LOW)
			|| (i_osc_mode == RSS_OSC_XTAL_MID)
			|| (i_osc_mode == RSS_OSC_XTAL_HIGH);
		rc_rise = rc_s && !st.rc_d;
		ext_rise = ext_s && !st.ext_d;
		// Detector holds: power-on only while never yet powered
		supply_hold = (!st.powered && !supply_ok_s)
			|| (i_uv_en && !uv_ok_s);
		warm_evt = !clear_b_s || i_watchdog_reset_source;

		next_st = st;
		next_st.rc_d = rc_s;
		next_st.ext_d = ext_s;
		next_st.load_por = 1'b0;
		next_st.load_warm = 1'b0;
		if (supply_ok_s) begin
			next_st.powered = 1'b1;
		end

		unique case (st.state)
			RSS_HOLD: begin
				next_st.rst_b = 1'b0;
				if (i_uv_en && !uv_ok_s) begin
					next_st.uv_low = 1'b1;
				end
				if (!supply_hold && !warm_evt) begin
					next_st.pudt_cnt = '0;
					next_st.osc_cnt = '0;
					if ((st.cold || st.uv_low)
						&& !i_power_up_delay_disable_cfg) begin
						next_st.state = RSS_PUDT;
					end else if (st.cold && crystal) begin
						next_st.state = RSS_OSC_WAIT;
					end else begin
						next_st.state = RSS_RUN;
					end
				end
			end
			RSS_PUDT: begin
				next_st.rst_b = 1'b0;
				if (rc_rise) begin
					next_st.pudt_cnt = st.pudt_cnt + 12'h001;
				end
				if (supply_hold) begin
					next_st.state = RSS_HOLD;
				end else if (st.pudt_cnt == 12'(RSS_PUDT_TICKS)) begin
					next_st.state = (st.cold && crystal) ? RSS_OSC_WAIT
						: RSS_RUN;
				end
			end
			RSS_OSC_WAIT: begin
				next_st.rst_b = 1'b0;
				if (ext_rise) begin
					next_st.osc_cnt = st.osc_cnt + 11'h001;
				end
				if (supply_hold) begin
					next_st.state = RSS_HOLD;
				end else if (st.osc_cnt == 11'(RSS_OSC_STARTUP_CYCLES)) begin
					next_st.state = RSS_RUN;
				end
			end
			RSS_RUN: begin
				next_st.rst_b = 1'b1;
				next_st.cold = 1'b0;
				next_st.uv_low = 1'b0;
				if (i_uv_en && !uv_ok_s) begin
					next_st.uv_low = 1'b1;
					next_st.rst_b = 1'b0;
					next_st.state = RSS_HOLD;
				end else if (warm_evt) begin
					next_st.rst_b = 1'b0;
					next_st.state = RSS_HOLD;
				end else if (i_sleep_wake && crystal) begin
					next_st.osc_cnt = '0;
					next_st.rst_b = 1'b0;
					next_st.state = RSS_OSC_WAIT;
				end
			end
		endcase

		// Register initial values on reset entry from RUN to HOLD
		if (st.state == RSS_RUN && next_st.state == RSS_HOLD) begin
			next_st.load_warm = 1'b1;
			next_st.pc_low = RSS_PC_LOW_RST;
			next_st.status = {RSS_STATUS_WARM_HI[7:5],
				!i_watchdog_reset_source, clear_b_s, st.status[2:1],
				i_status_lo_keep};
			next_st.option = RSS_OPTION_RST;
			next_st.dir = RSS_DIR_RST;
			next_st.int_ctl = {RSS_INT_CTL_RST[7:1], st.int_ctl[0]};
			next_st.timer1_ctl = i_timer_one_control_reg;
		end
	end

	always_ff @(posedge i_mclk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			st <= '0;
			st.state <= RSS_HOLD;
			st.cold <= 1'b1;
			st.load_por <= 1'b1;
			st.pc_low <= RSS_PC_LOW_RST;
			st.status <= RSS_STATUS_POR;
			st.option <= RSS_OPTION_RST;
			st.dir <= RSS_DIR_RST;
			st.int_ctl <= RSS_INT_CTL_RST;
			st.timer1_ctl <= RSS_TIMER1_CTL_POR;
		end else begin
			st <= next_st;
		end
	end

	// ---------------------------------------------------------------
	// Outputs
	// ---------------------------------------------------------------
	assign o_chip_rst_b = st.rst_b;
	assign o_load_por = st.load_por;
	assign o_load_warm = st.load_warm;
	assign o_program_counter_low = st.pc_low;
	assign o_status = st.status;
	assign o_option = st.option;
	assign o_pin_direction_reg = st.dir;
	assign o_interrupt_control_reg = st.int_ctl;
	assign o_timer_one_control_reg = st.timer1_ctl;

endmodule // rss_seq
`default_nettype wire

// ---- dv/rss_seq_properties.sv ----
`timescale 1ns/10ps
`default_nettype none
module rss_seq_properties (
	input wire logic i_mclk, // Clock
	input wire logic i_rst_b, // Reset
	input wire logic i_supply_ok, // Supply
	input wire logic i_uv_en, // UV enable
	input wire logic i_uv_ok, // UV level
	input wire logic i_master_clear_pin_b, // Clear
	input wire logic i_watchdog_reset_source, // Watchdog
	input wire logic [6:0] i_timer_one_control_reg, // Timer ctl in
	input wire logic o_chip_rst_b, // Chip reset
	input wire logic o_load_warm, // Warm load
	input wire logic o_load_por, // Power-on load
	input wire logic [7:0] o_program_counter_low, // PC low
	input wire logic [7:0] o_status, // Status
	input wire logic [7:0] o_option, // Option
	input wire logic [5:0] o_pin_direction_reg, // Direction
	input wire logic [7:0] o_interrupt_control_reg, // Int ctl
	input wire logic [6:0] o_timer_one_control_reg // Timer ctl out
);
	// --------
	// Checks
	// --------
	default clocking @(posedge i_mclk); endclocking
	default disable iff (!i_rst_b);
	a_supply_first: assert property ($rose(o_chip_rst_b) |-> $past(i_supply_ok, 3))
		else $error("release without good supply");
	a_uv_hold: assert property ((i_uv_en && !i_uv_ok) [*5] |-> !o_chip_rst_b)
		else $error("running below undervoltage level");
	a_clear_hold: assert property (!i_master_clear_pin_b [*5] |-> !o_chip_rst_b)
		else $error("running with clear low");
	a_release_ok: assert property ($rose(o_chip_rst_b) |-> $past(i_master_clear_pin_b, 3) && (!$past(i_uv_en, 3) || $past(i_uv_ok, 3)))
		else $error("release with a hold source active");
	a_clear_fast: assert property ($rose(i_master_clear_pin_b) |-> ##[1:8] o_chip_rst_b)
		else $error("clear release too slow");
	a_por_values: assert property (!$past(i_rst_b) |-> o_program_counter_low == 8'h00 && o_status[7:3] == 5'h03 && o_option == 8'hFF && o_pin_direction_reg == 6'h3F && o_interrupt_control_reg == 8'h00 && o_timer_one_control_reg == 7'h00)
		else $error("wrong cold values");
	a_warm_values: assert property (o_load_warm |-> ##[0:1] (o_program_counter_low == 8'h00 && o_status[7:5] == 3'h0 && o_interrupt_control_reg[7:1] == 7'h00))
		else $error("wrong warm values");
	a_warm_timer: assert property (o_load_warm && $stable(i_timer_one_control_reg) |-> ##[0:1] o_timer_one_control_reg == i_timer_one_control_reg)
		else $error("timer control not kept");
	a_watchdog_load: assert property ($rose(i_watchdog_reset_source) && o_chip_rst_b |-> ##[1:4] o_load_warm)
		else $error("watchdog gave no warm load");
	a_por_pulse: assert property (o_load_por |=> !o_load_por)
		else $error("power-on load not a single pulse");
endmodule // rss_seq_properties
bind rss_seq rss_seq_properties u_props (
	.i_mclk(i_mclk),
	.i_rst_b(i_rst_b),
	.i_supply_ok(i_supply_ok),
	.i_uv_en(i_uv_en),
	.i_uv_ok(i_uv_ok),
	.i_master_clear_pin_b(i_master_clear_pin_b),
	.i_watchdog_reset_source(i_watchdog_reset_source),
	.i_timer_one_control_reg(i_timer_one_control_reg),
	.o_chip_rst_b(o_chip_rst_b),
	.o_load_warm(o_load_warm),
	.o_load_por(o_load_por),
	.o_program_counter_low(o_program_counter_low),
	.o_status(o_status),
	.o_option(o_option),
	.o_pin_direction_reg(o_pin_direction_reg),
	.o_interrupt_control_reg(o_interrupt_control_reg),
	.o_timer_one_control_reg(o_timer_one_control_reg)
);
`default_nettype wire

// ---- dv/test_reset_startup_sequencer.sv ----
`timescale 1ns/10ps
`default_nettype none
module test_reset_startup_sequencer;
	import rss_pkg::*;
	localparam int RC_P = 4;
	localparam int EXT_P = 6;
	logic i_mclk = 0, i_rst_b = 0, i_supply_ok = 0, i_uv_en = 0, i_uv_ok = 0;
	logic i_power_up_delay_disable_cfg = 0, i_rc_osc = 0;
	logic i_external_osc_input = 0, i_watchdog_reset_source = 0;
	logic i_master_clear_pin_b = 1;
	logic i_sleep_wake = 0, i_status_lo_keep = 1;
	logic [1:0] rc_div = 2'h0, ext_div = 2'h0;
	logic [2:0] i_osc_mode = 3'h1;
	logic [6:0] i_timer_one_control_reg = 7'h5A;
	logic o_chip_rst_b, o_load_por, o_load_warm;
	logic [7:0] o_program_counter_low, o_status, o_option;
	logic [7:0] o_interrupt_control_reg;
	logic [5:0] o_pin_direction_reg;
	logic [6:0] o_timer_one_control_reg;
	int fails = 0, compares = 0;
	always #4 i_mclk = ~i_mclk;
	// RC and external oscillator pins, stepped on the rising edge
	always @(posedge i_mclk) begin
		rc_div <= rc_div + 2'h1;
		i_rc_osc <= rc_div[1];
		ext_div <= (ext_div == 2'h2) ? 2'h0 : ext_div + 2'h1;
		if (ext_div == 2'h2) begin
			i_external_osc_input <= ~i_external_osc_input;
		end
	end
	rss_seq u_dut (
		.i_mclk(i_mclk),
		.i_rst_b(i_rst_b),
		.i_supply_ok(i_supply_ok),
		.i_uv_en(i_uv_en),
		.i_uv_ok(i_uv_ok),
		.i_power_up_delay_disable_cfg(i_power_up_delay_disable_cfg),
		.i_rc_osc(i_rc_osc),
		.i_external_osc_input(i_external_osc_input),
		.i_osc_mode(i_osc_mode),
		.i_master_clear_pin_b(i_master_clear_pin_b),
		.i_watchdog_reset_source(i_watchdog_reset_source),
		.i_sleep_wake(i_sleep_wake),
		.i_timer_one_control_reg(i_timer_one_control_reg),
		.i_status_lo_keep(i_status_lo_keep),
		.o_chip_rst_b(o_chip_rst_b),
		.o_load_por(o_load_por),
		.o_load_warm(o_load_warm),
		.o_program_counter_low(o_program_counter_low),
		.o_status(o_status),
		.o_option(o_option),
		.o_pin_direction_reg(o_pin_direction_reg),
		.o_interrupt_control_reg(o_interrupt_control_reg),
		.o_timer_one_control_reg(o_timer_one_control_reg)
	);
	// ----------
	// Scenarios
	// ----------
	task automatic check(string name, logic [7:0] seen, logic [7:0] exp);
		compares++;
		if (seen !== exp) begin
			fails++;
			$display("mismatch %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task automatic finish_test();
		$display("compares %0d fails %0d", compares, fails);
		if (fails == 0 && compares > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	task automatic wait_run(string name, int exp);
		int n = 0;
		while (o_chip_rst_b !== 1'h1 && n < exp + 40) begin
			@(posedge i_mclk);
			n++;
		end
		check(name, n >= exp - 8 && n <= exp + 24, 1'h1);
	endtask
	task automatic cold(logic [2:0] mode, logic cfg, int exp);
		i_rst_b <= 1'h0;
		i_supply_ok <= 1'h0;
		i_uv_en <= 1'h0;
		i_osc_mode <= mode;
		i_power_up_delay_disable_cfg <= cfg;
		repeat (12) @(posedge i_mclk);
		check("por_pulse", o_load_por, 1'h1);
		i_rst_b <= 1'h1;
		repeat (20) @(posedge i_mclk);
		check("held_low_supply", o_chip_rst_b, 1'h0);
		check("por_done", o_load_por, 1'h0);
		i_supply_ok <= 1'h1;
		wait_run("cold_release", exp);
		check("cold_pc_low", o_program_counter_low, 8'h00);
		check("cold_status", o_status & 8'hF8, 8'h18);
		check("cold_option", o_option, 8'hFF);
		check("cold_dir", o_pin_direction_reg, 6'h3F);
		check("cold_int_ctl", o_interrupt_control_reg, 8'h00);
		check("cold_timer", o_timer_one_control_reg, 7'h00);
	endtask
	task automatic warm();
		i_master_clear_pin_b <= 1'h0;
		repeat (6) @(posedge i_mclk);
		check("clear_held", o_chip_rst_b, 1'h0);
		i_master_clear_pin_b <= 1'h1;
		wait_run("clear_release", 0);
		check("clear_status", o_status & 8'hF0, 8'h10);
		check("clear_status_lo", o_status & 8'h01, 8'h01);
		check("clear_int_ctl", o_interrupt_control_reg & 8'hFE, 8'h00);
		check("clear_timer", o_timer_one_control_reg, 7'h5A);
		i_watchdog_reset_source <= 1'h1;
		@(posedge i_mclk);
		i_watchdog_reset_source <= 1'h0;
		@(posedge i_mclk);
		check("watchdog_held", o_chip_rst_b, 1'h0);
		wait_run("watchdog_release", 0);
		check("watchdog_status", o_status & 8'hF0, 8'h00);
	endtask
	task automatic wake();
		i_sleep_wake <= 1'h1;
		@(posedge i_mclk);
		i_sleep_wake <= 1'h0;
		repeat (2) @(posedge i_mclk);
		check("wake_held", o_chip_rst_b, 1'h0);
		wait_run("wake_release", RSS_OSC_STARTUP_CYCLES * EXT_P);
	endtask
	task automatic brownout();
		i_power_up_delay_disable_cfg <= 1'h0;
		i_uv_en <= 1'h1;
		i_uv_ok <= 1'h0;
		repeat (10) @(posedge i_mclk);
		check("uv_held", o_chip_rst_b, 1'h0);
		i_uv_ok <= 1'h1;
		wait_run("uv_release", RSS_PUDT_TICKS * RC_P);
		i_supply_ok <= 1'h0;
		repeat (20) @(posedge i_mclk);
		check("supply_fall", o_chip_rst_b, 1'h1);
	endtask
	initial begin
		cold(3'h4, 1'h1, 0);
		cold(3'h4, 1'h0, RSS_PUDT_TICKS * RC_P);
		cold(RSS_OSC_XTAL_LOW, 1'h1, RSS_OSC_STARTUP_CYCLES * EXT_P);
		cold(RSS_OSC_XTAL_HIGH, 1'h1, RSS_OSC_STARTUP_CYCLES * EXT_P);
		cold(RSS_OSC_XTAL_MID, 1'h0,
			RSS_PUDT_TICKS * RC_P + RSS_OSC_STARTUP_CYCLES * EXT_P);
		warm();
		wake();
		brownout();
		finish_test();
	end
	initial begin
		#600000;
		fails++;
		finish_test();
	end
endmodule // test_reset_startup_sequencer
`default_nettype wire
